//--- design/tmc_bufreg.sv
// One double-buffered value: the live register, its buffer and the valid flag.
// Assumes update already carries the lock and the transfer condition.
`timescale 1ns/10ps
module tmc_bufreg #(
  parameter logic [15:0] RESET_VAL = 16'h0000
) (
  input  wire logic               clock,
  input  wire logic               srst,
  input  wire logic               reg_wr,
  input  wire logic               buf_wr,
  input  wire logic               update,
  input  wire tmc_pkg::tmc_word_t wdata,
  output tmc_pkg::tmc_word_t      value,
  output tmc_pkg::tmc_word_t      buffer,
  output logic                    valid
);
  import tmc_pkg::*;

  always_ff @(posedge clock) begin
    if (srst) begin
      value  <= RESET_VAL;
      buffer <= WORD_ZERO;
      valid  <= 1'b0;
    end else begin
      if (reg_wr) begin
        value <= wdata;
      end else if (update && valid) begin
        value <= buffer;
      end
      if (buf_wr) begin
        buffer <= wdata;
      end
      // A write in the transfer cycle keeps the flag set.
      valid <= buf_wr || (valid && !update);
    end
  end

  AST_BV_SET: assert property (@(posedge clock) disable iff (srst)
    buf_wr |=> valid && buffer == $past(wdata))
    else $error("Buffer write did not set its valid flag.");

  AST_XFER: assert property (@(posedge clock) disable iff (srst)
    update && valid && !reg_wr && !buf_wr |=> !valid && value == $past(buffer))
    else $error("Buffer transfer did not move the value.");

endmodule : tmc_bufreg

//--- design/tmc_pkg.sv
// Package for the sixteen-bit timer with compare channels.
// Assumes one 250 MHz clock and a plain word-indexed register port.
package tmc_pkg;

  localparam int unsigned DATA_W  = 16;
  localparam int unsigned ADDR_W  = 4;
  localparam int unsigned NUM_CH  = 3;
  localparam int unsigned NUM_BUF = 4;
  localparam int unsigned NUM_WO  = 6;
  localparam int unsigned PRESC_W = 10;
  localparam int unsigned SEL_W   = 3;
  localparam int unsigned WGM_W   = 3;

  // Register indices.
  localparam logic [3:0] ADDR_CONTROL_A_REGISTER    = 4'h0;
  localparam logic [3:0] ADDR_CONTROL_B_REGISTER    = 4'h1;
  localparam logic [3:0] ADDR_CONTROL_E_REGISTER    = 4'h2;
  localparam logic [3:0] ADDR_CONTROL_F_REGISTER    = 4'h3;
  localparam logic [3:0] ADDR_INTFLAGS = 4'h4;
  localparam logic [3:0] ADDR_CNT      = 4'h5;
  localparam logic [3:0] ADDR_REG_BASE = 4'h6;
  localparam logic [3:0] ADDR_BUF_BASE = 4'hA;

  // Field positions.
  localparam int unsigned CONTROL_A_REGISTER_EN_BIT     = 0;
  localparam int unsigned CONTROL_A_REGISTER_SEL_LSB    = 1;
  localparam int unsigned CONTROL_B_REGISTER_WGM_LSB    = 0;
  localparam int unsigned CONTROL_B_REGISTER_CMPEN_LSB  = 4;
  localparam int unsigned CONTROL_E_REGISTER_DIR_BIT    = 0;
  localparam int unsigned CONTROL_E_REGISTER_UPDATE_LOCK_BIT_BIT   = 1;

  // Reset and boundary values.
  localparam logic [15:0] WORD_ZERO   = 16'h0000;
  localparam logic [15:0] COUNT_FLOOR = 16'h0000;
  localparam logic [15:0] PER_RESET   = 16'hFFFF;
  localparam logic [15:0] CNT_STEP    = 16'h0001;
  localparam logic [9:0]  PRESC_ZERO  = 10'h000;
  localparam logic [9:0]  PRESC_STEP  = 10'h001;

  typedef logic [15:0] tmc_word_t;

  typedef enum logic [2:0] {
    TMC_WG_NORMAL = 3'h0,
    TMC_WG_FRQ    = 3'h1
  } tmc_waveform_mode_field_e;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } tmc_bus_req_s;

  // Mask of low prescaler bits that must all be set for a tick.
  function automatic logic [9:0] presc_mask(input logic [2:0] sel);
    unique case (sel)
      3'h0: presc_mask = 10'h000;
      3'h1: presc_mask = 10'h001;
      3'h2: presc_mask = 10'h003;
      3'h3: presc_mask = 10'h007;
      3'h4: presc_mask = 10'h00F;
      3'h5: presc_mask = 10'h03F;
      3'h6: presc_mask = 10'h0FF;
      3'h7: presc_mask = 10'h3FF;
    endcase
  endfunction : presc_mask

endpackage : tmc_pkg

//--- design/tmc_prescale.sv
// Prescaler that turns the peripheral clock into timer tick enables.
// Assumes the run input stays low while the timer is disabled.
`timescale 1ns/10ps
module tmc_prescale (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       run,
  input  wire logic [2:0] sel,
  output logic            tick
);
  import tmc_pkg::*;

  logic [9:0] pcnt;
  logic [9:0] mask;

  assign mask = presc_mask(sel);
  assign tick = run && ((pcnt & mask) == mask);

  always_ff @(posedge clock) begin
    if (srst || !run) begin
      pcnt <= PRESC_ZERO;
    end else begin
      pcnt <= pcnt + PRESC_STEP;
    end
  end

  AST_DIV_ONE: assert property (@(posedge clock) disable iff (srst)
    run && sel == 3'h0 |-> tick)
    else $error("Division by one does not tick every cycle.");

endmodule : tmc_prescale

//--- design/tmc_timer.sv
// Sixteen-bit timer core with period, three compare channels and toggle outputs.
// Assumes a register master that keeps strobes one cycle long and never both at once.
// Contract
// - Counter steps per tick in chosen direction
// - Ticks come from prescaled peripheral clock
// - Up count wraps to zero after ceiling
// - Down count reloads period at floor
// - Counter write wins over any counting
// - Direction change applies to later ticks
// - Period and compares have buffered valid flags
// - Buffer write sets flag, transfer clears
// - Compare and buffer both directly writable
// - Unbuffered period write takes effect at once
// - Period loads from buffer only at transfer
// - Compare match sets channel flag next tick
// - Compare buffer copies at transfer condition
// - Pin overridden only with mode and enable
// - Only three outputs outside split operation
// - Frequency mode: compare zero sets period
// - Frequency mode reaches half clock rate
// - Channels one, two give offset toggles
// - Compare change may invert channel output
// - Transfer at floor or ceiling unless locked
// - Floor is counter value zero
// - Counting starts only after enable set
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module tmc_timer (
  input  wire logic                 clock,
  input  wire logic                 srst,
  input  wire tmc_pkg::tmc_bus_req_s bus,
  output tmc_pkg::tmc_word_t        rdata,
  output logic [5:0]                waveform_output,
  output logic [5:0]                waveform_override
);
  import tmc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Control state.

  logic            control_enable;
  logic [2:0]      clock_prescale_select;
  tmc_waveform_mode_field_e     waveform_mode_field;
  logic [2:0]      compare_output_enable;
  logic            count_down;
  logic            update_lock_bit;
  tmc_word_t       counter_value;
  logic [2:0]      compare_flag;
  logic [2:0]      wave_state;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode.

  logic            wr_control_a_register;
  logic            wr_control_b_register;
  logic            wr_control_e_register;
  logic            wr_flags;
  logic            wr_cnt;
  logic [3:0]      reg_wr;
  logic [3:0]      buf_wr;

  assign wr_control_a_register = bus.wr && bus.addr == ADDR_CONTROL_A_REGISTER;
  assign wr_control_b_register = bus.wr && bus.addr == ADDR_CONTROL_B_REGISTER;
  assign wr_control_e_register = bus.wr && bus.addr == ADDR_CONTROL_E_REGISTER;
  assign wr_flags = bus.wr && bus.addr == ADDR_INTFLAGS;
  assign wr_cnt   = bus.wr && bus.addr == ADDR_CNT;

  genvar k;
  generate
    for (k = 0; k < NUM_BUF; k++) begin : g_dec
      assign reg_wr[k] = bus.wr && bus.addr == ADDR_REG_BASE + 4'(k);
      assign buf_wr[k] = bus.wr && bus.addr == ADDR_BUF_BASE + 4'(k);
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Tick generation.

  logic            tick;
  logic            run_tick;

  tmc_prescale u_prescale (
    .clock (clock),
    .srst  (srst),
    .run   (control_enable),
    .sel   (clock_prescale_select),
    .tick  (tick)
  );

  // Ticks exist only while enabled.
  assign run_tick = control_enable && tick;

  //////////////////////////////////////////////////////////////////////////////
  // Period and compare registers; index zero is the period.

  tmc_word_t       live_val [NUM_BUF];
  tmc_word_t       buf_val  [NUM_BUF];
  logic [3:0]      buf_valid;
  logic            update_go;

  generate
    for (k = 0; k < NUM_BUF; k++) begin : g_buf
      tmc_bufreg #(
        .RESET_VAL (k == 0 ? PER_RESET : WORD_ZERO)
      ) u_bufreg (
        .clock  (clock),
        .srst   (srst),
        .reg_wr (reg_wr[k]),
        .buf_wr (buf_wr[k]),
        .update (update_go),
        .wdata  (bus.wdata),
        .value  (live_val[k]),
        .buffer (buf_val[k]),
        .valid  (buf_valid[k])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Count sequence.

  logic            frq_mode;
  tmc_word_t       count_top;
  logic            at_top;
  logic            at_floor;
  logic            update_cond;
  tmc_word_t       step_val;
  tmc_word_t       next_counter;

  assign frq_mode  = waveform_mode_field == TMC_WG_FRQ;
  // Compare zero replaces the period in frequency mode.
  assign count_top = frq_mode ? live_val[1] : live_val[0];
  // Live comparison: a counter above a freshly lowered top runs on to wrap.
  assign at_top    = counter_value == count_top;
  assign at_floor  = counter_value == COUNT_FLOOR;

  assign update_cond = run_tick && (count_down ? at_floor : at_top);
  assign update_go   = update_cond && !update_lock_bit;

  assign step_val = count_down ? (at_floor ? count_top : counter_value - CNT_STEP)
                               : (at_top ? COUNT_FLOOR : counter_value + CNT_STEP);

  // A software write beats any step, clear or reload in the same cycle.
  assign next_counter = wr_cnt   ? bus.wdata :
                        run_tick ? step_val  :
                        counter_value;

  //////////////////////////////////////////////////////////////////////////////
  // Compare channels.

  logic [2:0]      match;
  logic [2:0]      match_tick;
  logic [2:0]      next_flag;
  logic [2:0]      next_wave;

  generate
    for (k = 0; k < NUM_CH; k++) begin : g_cmp
      assign match[k] = counter_value == live_val[k + 1];
    end
  endgenerate

  assign match_tick = match & {3{run_tick}};
  // Set wins over a software clear in the same cycle.
  assign next_flag  = (compare_flag & ~(bus.wdata[2:0] & {3{wr_flags}})) | match_tick;
  // In frequency mode each channel toggles on its own match; offsets follow from the compare values,
  // so changing one mid-run can leave that output inverted against output zero.
  assign next_wave  = wave_state ^ (match_tick & {3{frq_mode}});

  //////////////////////////////////////////////////////////////////////////////
  // Control register next values and pin override.

  logic            next_enable;
  logic [2:0]      next_sel;
  tmc_waveform_mode_field_e     next_mode;
  logic [2:0]      next_cmpen;
  logic            next_down;
  logic            next_update_lock_bit;
  logic            next_active;
  logic [5:0]      next_override;

  assign next_enable = wr_control_a_register ? bus.wdata[CONTROL_A_REGISTER_EN_BIT] : control_enable;
  assign next_sel    = wr_control_a_register ? bus.wdata[CONTROL_A_REGISTER_SEL_LSB +: SEL_W] : clock_prescale_select;
  assign next_mode   = wr_control_b_register ? tmc_waveform_mode_field_e'(bus.wdata[CONTROL_B_REGISTER_WGM_LSB +: WGM_W])
                                : waveform_mode_field;
  assign next_cmpen  = wr_control_b_register ? bus.wdata[CONTROL_B_REGISTER_CMPEN_LSB +: NUM_CH]
                                : compare_output_enable;
  assign next_down   = wr_control_e_register ? bus.wdata[CONTROL_E_REGISTER_DIR_BIT] : count_down;
  assign next_update_lock_bit   = wr_control_e_register ? bus.wdata[CONTROL_E_REGISTER_UPDATE_LOCK_BIT_BIT] : update_lock_bit;

  // Override only with a waveform mode chosen and the channel enabled.
  assign next_active   = next_mode != TMC_WG_NORMAL;
  // Upper three outputs belong to split operation, which this core lacks.
  assign next_override = {3'h0, next_cmpen & {3{next_active}}};

  //////////////////////////////////////////////////////////////////////////////
  // Read mux.

  tmc_word_t       read_mux;

  always_comb begin
    read_mux = WORD_ZERO;
    unique case (bus.addr)
      ADDR_CONTROL_A_REGISTER:    read_mux = {12'h000, clock_prescale_select, control_enable};
      ADDR_CONTROL_B_REGISTER:    read_mux = {9'h000, compare_output_enable, 1'b0, waveform_mode_field};
      ADDR_CONTROL_E_REGISTER:    read_mux = {14'h0000, update_lock_bit, count_down};
      ADDR_CONTROL_F_REGISTER:    read_mux = {12'h000, buf_valid};
      ADDR_INTFLAGS: read_mux = {13'h0000, compare_flag};
      ADDR_CNT:      read_mux = counter_value;
      4'h6, 4'h7, 4'h8, 4'h9:
        read_mux = live_val[bus.addr[1:0] - 2'h2];
      4'hA, 4'hB, 4'hC, 4'hD:
        read_mux = buf_val[bus.addr[1:0] - 2'h2];
      default:       read_mux = WORD_ZERO;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // State registers.

  always_ff @(posedge clock) begin
    if (srst) begin
      control_enable        <= 1'b0;
      clock_prescale_select <= 3'h0;
      waveform_mode_field   <= TMC_WG_NORMAL;
      compare_output_enable <= 3'h0;
      count_down            <= 1'b0;
      update_lock_bit       <= 1'b0;
    end else begin
      control_enable        <= next_enable;
      clock_prescale_select <= next_sel;
      waveform_mode_field   <= next_mode;
      compare_output_enable <= next_cmpen;
      count_down            <= next_down;
      update_lock_bit       <= next_update_lock_bit;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      counter_value <= WORD_ZERO;
      compare_flag  <= 3'h0;
      wave_state    <= 3'h0;
    end else begin
      counter_value <= next_counter;
      compare_flag  <= next_flag;
      wave_state    <= next_wave;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      waveform_override <= 6'h00;
      rdata             <= WORD_ZERO;
    end else begin
      waveform_override <= next_override;
      rdata             <= bus.rd ? read_mux : WORD_ZERO;
    end
  end

  // Pin value follows the toggle state directly; override decides whether it shows.
  assign waveform_output = {3'h0, wave_state};

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  AST_HOLD_DISABLED: assert property (@(posedge clock) disable iff (srst)
    !control_enable && !wr_cnt |=> counter_value == $past(counter_value))
    else $error("Counter moved while disabled.");

  AST_CNT_WRITE: assert property (@(posedge clock) disable iff (srst)
    wr_cnt |=> counter_value == $past(bus.wdata))
    else $error("Counter write lost to counting.");

  AST_UP_STEP: assert property (@(posedge clock) disable iff (srst)
    run_tick && !count_down && !at_top && !wr_cnt
    |=> counter_value == $past(counter_value) + CNT_STEP)
    else $error("Up count did not step by one.");

  AST_DOWN_STEP: assert property (@(posedge clock) disable iff (srst)
    run_tick && count_down && !at_floor && !wr_cnt
    |=> counter_value == $past(counter_value) - CNT_STEP)
    else $error("Down count did not step by one.");

  AST_WRAP: assert property (@(posedge clock) disable iff (srst)
    run_tick && !count_down && at_top && !wr_cnt |=> counter_value == COUNT_FLOOR)
    else $error("Counter did not wrap to zero at top.");

  AST_RELOAD: assert property (@(posedge clock) disable iff (srst)
    run_tick && count_down && at_floor && !wr_cnt |=> counter_value == $past(count_top))
    else $error("Counter did not reload at floor.");

  AST_LOCK: assert property (@(posedge clock) disable iff (srst)
    update_lock_bit && update_cond && buf_valid[0] |=> buf_valid[0])
    else $error("Locked update cleared a buffer flag.");

  AST_FLAG_SET: assert property (@(posedge clock) disable iff (srst)
    run_tick && match[0] |=> compare_flag[0])
    else $error("Compare match did not set its flag.");

  AST_FLAG_STICKY: assert property (@(posedge clock) disable iff (srst)
    compare_flag[1] && !wr_flags |=> compare_flag[1])
    else $error("Compare flag dropped without a clear.");

  AST_FRQ_TOGGLE: assert property (@(posedge clock) disable iff (srst)
    frq_mode && run_tick && match[2] |=> wave_state[2] != $past(wave_state[2]))
    else $error("Frequency output did not toggle on match.");

  AST_HALF_RATE: assert property (@(posedge clock) disable iff (srst)
    frq_mode && control_enable && clock_prescale_select == 3'h0 && live_val[1] == WORD_ZERO
    && counter_value == WORD_ZERO && !bus.wr
    |=> wave_state[0] != $past(wave_state[0]))
    else $error("Frequency output not at half clock rate.");

  AST_NO_OVERRIDE: assert property (@(posedge clock) disable iff (srst)
    waveform_mode_field == TMC_WG_NORMAL && !wr_control_b_register |=> waveform_override == 6'h00)
    else $error("Pin overridden without a waveform mode.");

  AST_UPPER_LOW: assert property (@(posedge clock) disable iff (srst)
    waveform_override[5:3] == 3'h0 && waveform_output[5:3] == 3'h0)
    else $error("Upper waveform outputs active.");

  AST_FLAG_CLEAR: assert property (@(posedge clock) disable iff (srst)
    wr_flags && bus.wdata[0] && !match_tick[0] |=> !compare_flag[0])
    else $error("Compare flag write of one did not clear it.");

  AST_FLAG_QUIET: assert property (@(posedge clock) disable iff (srst)
    !run_tick && !wr_flags |=> compare_flag == $past(compare_flag))
    else $error("Compare flag changed without a tick.");

  AST_OVR_ON: assert property (@(posedge clock) disable iff (srst)
    wr_control_b_register && bus.wdata[CONTROL_B_REGISTER_WGM_LSB +: WGM_W] != 3'h0
    |=> waveform_override[2:0] == $past(bus.wdata[CONTROL_B_REGISTER_CMPEN_LSB +: NUM_CH]))
    else $error("Enabled channel did not override its pin.");

  AST_NO_TOGGLE: assert property (@(posedge clock) disable iff (srst)
    !frq_mode |=> wave_state == $past(wave_state))
    else $error("Waveform toggled outside frequency mode.");

  AST_CMP_XFER: assert property (@(posedge clock) disable iff (srst)
    update_go && buf_valid[1] && !reg_wr[1] |=> live_val[1] == $past(buf_val[1]))
    else $error("Compare buffer not moved at the transfer condition.");

  AST_PER_STILL: assert property (@(posedge clock) disable iff (srst)
    !update_go && !reg_wr[0] |=> live_val[0] == $past(live_val[0]))
    else $error("Period moved outside the transfer condition.");

endmodule : tmc_timer

//--- test/timer_counter_16bit_compare_test.sv
// Self-checking bench for the timer: register tasks and scenario sequences.
// Assumes the timer core and the pin model are compiled before this file.
`timescale 1ns/10ps
module timer_counter_16bit_compare_test;
  import tmc_pkg::*;
  logic         clock     = 1'b0;
  logic         srst      = 1'b1;
  tmc_bus_req_s bus       = '0;
  logic [5:0]   dir_out   = 6'h3F;
  logic [5:0]   invert    = 6'h00;
  logic [5:0]   port_out  = 6'h00;
  tmc_word_t    rdata;
  logic [5:0]   wo;
  logic [5:0]   ovr;
  logic [5:0]   pin;
  int           err_count = 0;
  int           checks    = 0;
  int           div[8]    = '{1, 2, 4, 8, 16, 64, 256, 1024};
  tmc_word_t    q[$];
  logic [2:0]   w[$];

  always #2 clock = ~clock;

  tmc_timer i_tmc_timer (.clock(clock), .srst(srst), .bus(bus), .rdata(rdata),
    .waveform_output(wo), .waveform_override(ovr));
  tmc_pin_model i_tmc_pin_model (.wo(wo), .ovr(ovr), .dir_out(dir_out),
    .invert(invert), .port_out(port_out), .pin(pin));

  //////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input tmc_word_t g, input tmc_word_t e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : cmp

  task automatic wr(input logic [3:0] a, input tmc_word_t v);
    @(posedge clock);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clock);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input tmc_word_t e);
    @(posedge clock);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clock);
    bus <= '0;
    #1 cmp(rdata, e);
  endtask : rd

  // Reads the counter on every cycle, so each sample is one clock apart.
  task automatic smp(input int n);
    q.delete();
    w.delete();
    @(posedge clock);
    bus <= '{ADDR_CNT, 16'h0000, 1'b0, 1'b1};
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      if (i == n - 1) bus <= '0;
      #1;
      q.push_back(rdata);
      w.push_back(wo[2:0]);
    end
  endtask : smp

  task automatic seq(input tmc_word_t top, input logic down);
    tmc_word_t e;
    for (int i = 1; i < q.size(); i++) begin
      if (down) e = (q[i-1] == 16'h0000) ? top : q[i-1] - 16'h0001;
      else e = (q[i-1] == top) ? 16'h0000 : q[i-1] + 16'h0001;
      cmp(q[i], e);
    end
  endtask : seq

  task automatic toggles(input int b, input int e);
    int t;
    t = 0;
    for (int i = 1; i < w.size(); i++) t += int'(w[i][b] != w[i-1][b]);
    cmp(16'(t), 16'(e));
  endtask : toggles

  task automatic ovchk(input tmc_word_t e);
    @(posedge clock);
    #1 cmp({10'h000, ovr}, e);
  endtask : ovchk

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clock);
    err_count++;
    complete_run();
  end

  initial begin
    int a;
    int b;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    rd(ADDR_REG_BASE, PER_RESET);
    rd(ADDR_CONTROL_F_REGISTER, 16'h0000);
    repeat (10) @(posedge clock);
    rd(ADDR_CNT, 16'h0000);
    rd(4'hE, 16'h0000);
    wr(ADDR_REG_BASE, 16'h0002);
    wr(ADDR_CONTROL_A_REGISTER, 16'h0001);
    smp(12);
    seq(16'h0002, 1'b0);
    wr(ADDR_CONTROL_E_REGISTER, 16'h0001);
    smp(12);
    seq(16'h0002, 1'b1);
    wr(ADDR_CONTROL_E_REGISTER, 16'h0000);
    wr(ADDR_REG_BASE, 16'hFFFF);
    wr(ADDR_CNT, 16'h0100);
    wr(ADDR_REG_BASE, 16'h0010);
    smp(20);
    cmp({15'h0000, q[0] > 16'h0100 && q[0] < 16'h0108}, 16'h0001);
    seq(16'h0010, 1'b0);
    wr(ADDR_CNT, 16'h4321);
    smp(1);
    cmp({15'h0000, q[0] - 16'h4321 < 16'h0004}, 16'h0001);
    wr(ADDR_REG_BASE, 16'hFFFF);
    for (int s = 1; s < 8; s++) begin
      wr(ADDR_CONTROL_A_REGISTER, 16'((s << 1) | 1));
      smp(3 * div[s] + 2);
      a = 0;
      b = 0;
      for (int i = 1; i < q.size(); i++) begin
        if (q[i] != q[i-1] && a == 0) a = i;
        else if (q[i] != q[i-1] && b == 0) b = i;
      end
      cmp(16'(b - a), 16'(div[s]));
    end
    // Lock first, so the buffers must wait for the lock to drop.
    wr(ADDR_CONTROL_A_REGISTER, 16'h0000);
    wr(ADDR_CNT, 16'h0000);
    wr(ADDR_REG_BASE, 16'h0003);
    wr(ADDR_CONTROL_E_REGISTER, 16'h0002);
    for (int i = 0; i < 4; i++) wr(ADDR_BUF_BASE + 4'(i), 16'(i == 0 ? 5 : i));
    rd(ADDR_CONTROL_F_REGISTER, 16'h000F);
    rd(ADDR_REG_BASE, 16'h0003);
    wr(ADDR_CONTROL_A_REGISTER, 16'h0001);
    repeat (20) @(posedge clock);
    rd(ADDR_CONTROL_F_REGISTER, 16'h000F);
    rd(ADDR_REG_BASE, 16'h0003);
    wr(ADDR_CONTROL_E_REGISTER, 16'h0000);
    repeat (20) @(posedge clock);
    rd(ADDR_CONTROL_F_REGISTER, 16'h0000);
    rd(ADDR_REG_BASE, 16'h0005);
    for (int i = 1; i < 4; i++) rd(ADDR_REG_BASE + 4'(i), 16'(i));
    rd(ADDR_INTFLAGS, 16'h0007);
    wr(ADDR_CONTROL_A_REGISTER, 16'h0000);
    wr(ADDR_INTFLAGS, 16'h0001);
    rd(ADDR_INTFLAGS, 16'h0006);
    wr(ADDR_INTFLAGS, 16'h0000);
    rd(ADDR_INTFLAGS, 16'h0006);
    wr(ADDR_REG_BASE + 4'h1, 16'h0AAA);
    rd(ADDR_REG_BASE + 4'h1, 16'h0AAA);
    rd(ADDR_BUF_BASE + 4'h1, 16'h0001);
    rd(ADDR_CONTROL_F_REGISTER, 16'h0000);
    wr(ADDR_CNT, 16'h0000);
    wr(ADDR_REG_BASE + 4'h1, 16'h0000);
    wr(ADDR_CONTROL_B_REGISTER, 16'h0070);
    ovchk(16'h0000);
    wr(ADDR_CONTROL_B_REGISTER, 16'h0001);
    ovchk(16'h0000);
    wr(ADDR_CONTROL_B_REGISTER, 16'h0072);
    ovchk(16'h0007);
    wr(ADDR_CONTROL_B_REGISTER, 16'h0071);
    ovchk(16'h0007);
    @(posedge clock);
    port_out <= 6'h3F;
    @(posedge clock);
    #1 cmp({10'h000, pin}, 16'h0038);
    @(posedge clock);
    invert <= 6'h01;
    @(posedge clock);
    #1 cmp({10'h000, pin}, 16'h0039);
    @(posedge clock);
    invert  <= 6'h00;
    dir_out <= 6'h3E;
    @(posedge clock);
    #1 cmp({10'h000, pin}, 16'h0039);
    @(posedge clock);
    dir_out <= 6'h3F;
    wr(ADDR_CONTROL_A_REGISTER, 16'h0001);
    smp(8);
    toggles(0, 7);
    wr(ADDR_CONTROL_A_REGISTER, 16'h0000);
    wr(ADDR_CNT, 16'h0000);
    for (int i = 1; i < 4; i++) wr(ADDR_REG_BASE + 4'(i), 16'(i == 1 ? 3 : i - 1));
    wr(ADDR_CONTROL_A_REGISTER, 16'h0001);
    smp(17);
    seq(16'h0003, 1'b0);
    toggles(0, 4);
    toggles(1, 4);
    toggles(2, 4);
    complete_run();
  end
endmodule : timer_counter_16bit_compare_test

//--- test/tmc_pin_model.sv
// Port pin model standing behind the timer's six waveform outputs.
// Assumes the bench plays the port: direction, inversion and output level.
`timescale 1ns/10ps
module tmc_pin_model (
  input  wire logic [5:0] wo,
  input  wire logic [5:0] ovr,
  input  wire logic [5:0] dir_out,
  input  wire logic [5:0] invert,
  input  wire logic [5:0] port_out,
  output logic      [5:0] pin
);
  // An input pin floats to its pull-up, so a stale level is never seen.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (!dir_out[i]) begin
        pin[i] = 1'b1;
      end else begin
        pin[i] = ovr[i] ? (wo[i] ^ invert[i]) : port_out[i];
      end
    end
  end
endmodule : tmc_pin_model
